//--- ccid_defines.svh
// Register offsets, field positions, fixed read-one bits, unlock keys and timing counts
`ifndef CCID_DEFINES_SVH
`define CCID_DEFINES_SVH
`define CCID_OFS_CFGCTL     12'h000
`define CCID_OFS_PARTID     12'h004
`define CCID_OFS_RSTCTL     12'h008
`define CCID_OFS_PWRCTL     12'h00C
`define CCID_OFS_UNLOCK     12'h010
`define CCID_OFS_INTSTAT    12'h014
`define CCID_OFS_INTMASK    12'h018
`define CCID_OFS_PINSEL     12'h020
`define CCID_OFS_MODDIS     12'h024
`define CCID_BIT_PSLOCK     13
`define CCID_BIT_MDLOCK     12
`define CCID_BIT_DBGEN      3
`define CCID_BIT_TDOUSE     0
`define CCID_CFG_ONES       32'h0000_0006
`define CCID_BIT_BOR        1
`define CCID_BIT_SLEEP      0
// Unlock key words are arbitrary values
`define CCID_KEY1           32'h3C5A_0F96
`define CCID_KEY2           32'h69F0_A5C3
`define CCID_INT_BOR        0
`define CCID_INT_HOLDDONE   1
`define CCID_INT_LOCKREJ    2
`define CCID_INT_W          3
`define CCID_HOLD_NS        10000
`define CCID_CLK_MHZ        20
`define CCID_HOLD_CYC       ((`CCID_HOLD_NS * `CCID_CLK_MHZ + 999) / 1000)
`endif

//--- ccid_pkg.sv
// Types shared by the configuration control block
package ccid_pkg;
  typedef enum logic [1:0] {
    ccid_UNLOCK_IDLE = 2'b00,
    ccid_UNLOCK_KEY1 = 2'b01,
    ccid_UNLOCK_OPEN = 2'b10
  } ccid_unlock_t;
  typedef enum logic [1:0] {
    ccid_HOLD_RUN  = 2'b00,
    ccid_HOLD_WAIT = 2'b01,
    ccid_HOLD_DOWN = 2'b10
  } ccid_hold_t;
endpackage

//--- ccid_sync2.sv
// Two-flop synchroniser for one level from outside the clock domain
module ccid_sync2 (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1_q;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= 1'b0;
      syncOut  <= 1'b0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end
endmodule

//--- ccid_top.sv
// Configuration control, identification, hold-off and brown-out block on APB
//
// Functional notes
// - Pin-select lock blocks pin-select writes
// - Module-disable lock blocks module-disable writes
// - Debug port enable, read/write, resets one
// - Two-wire debug uses TDO when set
// - Unimplemented high bits read zero
// - Bits two and one read one
// - Revision identifier in bits 31:28
// - Part identifier bits 27:0, read-only
// - Hold execution after power-up and wake
// - Brown-out sets reset control flag
//
// The APB interface to the registers and the address map were chosen for this implementation.
`include "ccid_defines.svh"
module ccid_top #(
  parameter logic [3:0]  SILICON_REVISION = 4'h1,        // Arbitrary value
  parameter logic [27:0] PART_IDENTIFIER  = 28'h0123456, // Arbitrary value
  parameter int          HOLD_CYCLES      = `CCID_HOLD_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        brownOutPin,
  input  wire logic        wakePin,
  output logic             execEnable,
  output logic             debugPortEnable,
  output logic             twoWireTdoUse,
  output logic      [31:0] pinSelect,
  output logic      [31:0] moduleDisable,
  output logic             irq
);
  logic        pinSelLock_q;
  logic        modDisLock_q;
  logic        dbgEn_q;
  logic        tdoUse_q;
  logic        borFlag_q;
  logic        sleepReq_q;
  logic [2:0]  intStat_q;
  logic [2:0]  intMask_q;
  logic [31:0] holdCnt_q;
  logic        borSync;
  logic        wakeSync;
  logic        borSeen_q;
  ccid_pkg::ccid_unlock_t unlock_q;
  ccid_pkg::ccid_hold_t   hold_q;

  // Brown-out and wake pins cross into the clock domain
  ccid_sync2 uBorSync (
    .clock   (clock),
    .rst_n   (rst_n),
    .asyncIn (brownOutPin),
    .syncOut (borSync)
  );
  ccid_sync2 uWakeSync (
    .clock   (clock),
    .rst_n   (rst_n),
    .asyncIn (wakePin),
    .syncOut (wakeSync)
  );

  // Access phase decode, zero wait states
  wire access   = psel && penable;
  wire wrAcc    = access && pwrite;
  wire fullWord = (pstrb == 4'hF);
  wire selCfg   = (paddr == `CCID_OFS_CFGCTL);
  wire selId    = (paddr == `CCID_OFS_PARTID);
  wire selRst   = (paddr == `CCID_OFS_RSTCTL);
  wire selPwr   = (paddr == `CCID_OFS_PWRCTL);
  wire selKey   = (paddr == `CCID_OFS_UNLOCK);
  wire selStat  = (paddr == `CCID_OFS_INTSTAT);
  wire selMask  = (paddr == `CCID_OFS_INTMASK);
  wire selPin   = (paddr == `CCID_OFS_PINSEL);
  wire selMod   = (paddr == `CCID_OFS_MODDIS);
  wire mapped   = selCfg | selId | selRst | selPwr | selKey | selStat | selMask | selPin
                | selMod;
  wire wrCfg    = wrAcc && selCfg && pstrb[1] && pstrb[0];
  wire unlocked = (unlock_q == ccid_pkg::ccid_UNLOCK_OPEN);
  // Lock bits move only while unlocked
  wire lockChg  = (pwdata[`CCID_BIT_PSLOCK] != pinSelLock_q) ||
                  (pwdata[`CCID_BIT_MDLOCK] != modDisLock_q);
  wire lockOk   = wrCfg && unlocked;
  wire lockRej  = wrCfg && !unlocked && lockChg;
  wire wrPin    = wrAcc && selPin && fullWord && !pinSelLock_q;
  wire wrMod    = wrAcc && selMod && fullWord && !modDisLock_q;
  wire pinRej   = wrAcc && selPin && pinSelLock_q;
  wire modRej   = wrAcc && selMod && modDisLock_q;
  wire borRise  = borSync && !borSeen_q;
  wire holdDone = (hold_q == ccid_pkg::ccid_HOLD_WAIT) &&
                  (holdCnt_q == 32'(HOLD_CYCLES - 1));
  wire [2:0] intEvt;
  assign intEvt[`CCID_INT_BOR]      = borRise;
  assign intEvt[`CCID_INT_HOLDDONE] = holdDone;
  assign intEvt[`CCID_INT_LOCKREJ]  = lockRej | pinRej | modRej;

  wire [31:0] cfgRead = `CCID_CFG_ONES
                      | ({31'h0, pinSelLock_q} << `CCID_BIT_PSLOCK)
                      | ({31'h0, modDisLock_q} << `CCID_BIT_MDLOCK)
                      | ({31'h0, dbgEn_q} << `CCID_BIT_DBGEN)
                      | ({31'h0, tdoUse_q} << `CCID_BIT_TDOUSE);
  wire [31:0] idRead  = {SILICON_REVISION, PART_IDENTIFIER};
  wire [31:0] rstRead = {31'h0, borFlag_q} << `CCID_BIT_BOR;
  wire [31:0] rdMux   = selCfg  ? cfgRead :
                        selId   ? idRead :
                        selRst  ? rstRead :
                        selPwr  ? {31'h0, sleepReq_q} :
                        selKey  ? {30'h0, unlock_q} :
                        selStat ? {29'h0, intStat_q} :
                        selMask ? {29'h0, intMask_q} :
                        selPin  ? pinSelect :
                        selMod  ? moduleDisable : 32'h0000_0000;

  // APB answer, registered read data, error on unmapped address
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
    end
  end

  // Unlock sequence: two key writes in a row stay open until the next configuration control or unlock register write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unlock_q <= ccid_pkg::ccid_UNLOCK_IDLE;
    end else if (wrAcc && pready && selKey) begin
      if (pwdata == `CCID_KEY1) begin
        unlock_q <= ccid_pkg::ccid_UNLOCK_KEY1;
      end else if (pwdata == `CCID_KEY2 && unlock_q == ccid_pkg::ccid_UNLOCK_KEY1) begin
        unlock_q <= ccid_pkg::ccid_UNLOCK_OPEN;
      end else begin
        unlock_q <= ccid_pkg::ccid_UNLOCK_IDLE;
      end
    end else if (wrAcc && pready && !selKey && unlock_q != ccid_pkg::ccid_UNLOCK_OPEN) begin
      unlock_q <= ccid_pkg::ccid_UNLOCK_IDLE;
    end else if (wrCfg && pready) begin
      unlock_q <= ccid_pkg::ccid_UNLOCK_IDLE;
    end
  end

  // Configuration control bits; writes land on the pready edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinSelLock_q <= 1'b0;
      modDisLock_q <= 1'b0;
      dbgEn_q      <= 1'b1;
      tdoUse_q     <= 1'b1;
    end else if (wrCfg && pready) begin
      dbgEn_q  <= pwdata[`CCID_BIT_DBGEN];
      tdoUse_q <= pwdata[`CCID_BIT_TDOUSE];
      if (lockOk) begin
        pinSelLock_q <= pwdata[`CCID_BIT_PSLOCK];
        modDisLock_q <= pwdata[`CCID_BIT_MDLOCK];
      end
    end
  end

  // Guarded pin-select and module-disable stores
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pinSelect     <= 32'h0000_0000;
      moduleDisable <= 32'h0000_0000;
    end else begin
      if (wrPin && pready) pinSelect <= pwdata;
      if (wrMod && pready) moduleDisable <= pwdata;
    end
  end

  // brown-out flag, set wins over write-one clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      borFlag_q <= 1'b0;
      borSeen_q <= 1'b0;
    end else begin
      borSeen_q <= borSync;
      if (borRise) begin
        borFlag_q <= 1'b1;
      end else if (wrAcc && pready && selRst && pwdata[`CCID_BIT_BOR]) begin
        borFlag_q <= 1'b0;
      end
    end
  end

  // Interrupt status sticky, mask gates it; set beats clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      intStat_q <= 3'h0;
      intMask_q <= 3'h0;
      irq       <= 1'b0;
    end else begin
      if (wrAcc && pready && selStat) begin
        intStat_q <= (intStat_q & ~pwdata[2:0]) | intEvt;
      end else begin
        intStat_q <= intStat_q | intEvt;
      end
      if (wrAcc && pready && selMask) intMask_q <= pwdata[2:0];
      irq <= |(intStat_q & intMask_q);
    end
  end

  // execution hold-off after reset, brown-out and sleep wake
  // Brown-out forces a fresh hold, since the core lost its supply
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_q     <= ccid_pkg::ccid_HOLD_WAIT;
      holdCnt_q  <= 32'h0000_0000;
      sleepReq_q <= 1'b0;
      execEnable <= 1'b0;
    end else begin
      case (hold_q)
        ccid_pkg::ccid_HOLD_RUN: begin
          execEnable <= 1'b1;
          if (borSync) begin
            hold_q     <= ccid_pkg::ccid_HOLD_DOWN;
            execEnable <= 1'b0;
          end else if (wrAcc && pready && selPwr && pwdata[`CCID_BIT_SLEEP]) begin
            hold_q     <= ccid_pkg::ccid_HOLD_DOWN;
            sleepReq_q <= 1'b1;
            execEnable <= 1'b0;
          end
        end
        ccid_pkg::ccid_HOLD_DOWN: begin
          execEnable <= 1'b0;
          holdCnt_q  <= 32'h0000_0000;
          if (!borSync && (!sleepReq_q || wakeSync)) begin
            hold_q     <= ccid_pkg::ccid_HOLD_WAIT;
            sleepReq_q <= 1'b0;
          end
        end
        ccid_pkg::ccid_HOLD_WAIT: begin
          execEnable <= 1'b0;
          if (borSync) begin
            hold_q <= ccid_pkg::ccid_HOLD_DOWN;
          end else if (holdDone) begin
            hold_q     <= ccid_pkg::ccid_HOLD_RUN;
            execEnable <= 1'b1;
          end else begin
            holdCnt_q <= holdCnt_q + 32'h0000_0001;
          end
        end
        default: begin
          hold_q     <= ccid_pkg::ccid_HOLD_WAIT;
          execEnable <= 1'b0;
        end
      endcase
    end
  end

  // Config bits drive the debug logic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      debugPortEnable <= 1'b1;
      twoWireTdoUse   <= 1'b1;
    end else begin
      debugPortEnable <= dbgEn_q;
      twoWireTdoUse   <= tdoUse_q;
    end
  end

  // Checks
  // pin-select guard
  pin_lock_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrAcc && pready && selPin && pinSelLock_q) |=> $stable(pinSelect))
    else $error("pin-select changed while locked");
  mod_lock_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrAcc && pready && selMod && modDisLock_q) |=> $stable(moduleDisable))
    else $error("module-disable changed while locked");
  dbg_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrCfg && pready) |=> ##1 (debugPortEnable == $past(pwdata[`CCID_BIT_DBGEN], 2)))
    else $error("debug enable did not follow write");
  tdo_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrCfg && pready) |=> (tdoUse_q == $past(pwdata[`CCID_BIT_TDOUSE])))
    else $error("TDO use did not follow write");
  cfg_fixed_a: assert property (@(posedge clock) disable iff (!rst_n)
    (psel && !penable && !pwrite && selCfg) |=>
      ((prdata & 32'hFFFF_CFF6) == 32'h0000_0006))
    else $error("configuration fixed bits wrong");
  id_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    (psel && !penable && !pwrite && selId) |=>
      (prdata == {SILICON_REVISION, PART_IDENTIFIER}))
    else $error("identifier read wrong");
  hold_exec_a: assert property (@(posedge clock) disable iff (!rst_n)
    (hold_q == ccid_pkg::ccid_HOLD_WAIT && holdCnt_q == 32'h0000_0000) |=>
      !execEnable [*1])
    else $error("execution during hold-off");
  bor_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    borRise |=> borFlag_q)
    else $error("brown-out flag not set");
  lock_key_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrCfg && pready && !unlocked) |=> $stable(pinSelLock_q) && $stable(modDisLock_q))
    else $error("lock changed without unlock");
  irq_level_a: assert property (@(posedge clock) disable iff (!rst_n)
    (|(intStat_q & intMask_q)) |=> irq)
    else $error("interrupt not raised");
  pin_open_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrPin && pready) |=> (pinSelect == $past(pwdata)))
    else $error("pin-select write lost while open");
  mod_open_a: assert property (@(posedge clock) disable iff (!rst_n)
    (wrMod && pready) |=> (moduleDisable == $past(pwdata)))
    else $error("module-disable write lost while open");
  // Interrupt drops once nothing unmasked is pending
  irq_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(|(intStat_q & intMask_q)) |=> !irq)
    else $error("interrupt stuck high");
  // One access cycle per transfer, so pready never stands two cycles
  ready_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    pready |=> !pready)
    else $error("pready held too long");

  cov_unlock: cover property (@(posedge clock) disable iff (!rst_n) lockOk && pready);
  cov_reject: cover property (@(posedge clock) disable iff (!rst_n) pinRej && pready);
  cov_bor:    cover property (@(posedge clock) disable iff (!rst_n) borRise);
  cov_wake:   cover property (@(posedge clock) disable iff (!rst_n) holdDone);
  cov_sleep:  cover property (@(posedge clock) disable iff (!rst_n) sleepReq_q && wakeSync);
endmodule

//--- config_control_and_id_regs_tb_top.sv
// Self-checking bench for the configuration control and identification block
`include "ccid_defines.svh"
module config_control_and_id_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Short hold-off keeps the run brief; identifiers are arbitrary values
  localparam int          HOLD = 4;
  localparam logic [3:0]  REV  = 4'h1;
  localparam logic [27:0] PID  = 28'h0123456;
  logic        clock;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        brownOutPin;
  logic        wakePin;
  logic        execEnable;
  logic        debugPortEnable;
  logic        twoWireTdoUse;
  logic [31:0] pinSelect;
  logic [31:0] moduleDisable;
  logic        irq;
  int          nMismatch;
  int          checksDone;
  logic [3:0]  strbUse;

  // Free-running 20 MHz clock
  always #25 clock = ~clock;

  ccid_top #(.SILICON_REVISION(REV), .PART_IDENTIFIER(PID), .HOLD_CYCLES(HOLD)) i_ccid_top (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .brownOutPin(brownOutPin), .wakePin(wakePin),
    .execEnable(execEnable), .debugPortEnable(debugPortEnable),
    .twoWireTdoUse(twoWireTdoUse), .pinSelect(pinSelect), .moduleDisable(moduleDisable),
    .irq(irq));

  task automatic conclude;
    $display("Counts: compared %0d, mismatched %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timedOut(input string what);
    nMismatch++;
    $display("Error %s never came", what);
    conclude();
  endtask

  // One APB transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    pstrb   <= strbUse;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 20) timedOut("pready");
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, addr, wd, rd, err);
  endtask

  task automatic rdChk(input string what, input logic [11:0] addr, input logic [31:0] mask,
                       input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, addr, 32'h0000_0000, rd, err);
    chk(what, rd & mask, exp);
  endtask

  // Counts cycles until code may run; bounded so a stuck hold-off ends the run
  task automatic waitExec(output int n);
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (execEnable === 1'b1) break;
    end
    if (n == 100) timedOut("execEnable");
  endtask

  task automatic unlockSeq;
    wr(`CCID_OFS_UNLOCK, `CCID_KEY1);
    wr(`CCID_OFS_UNLOCK, `CCID_KEY2);
  endtask

  task automatic tResetAndId;
    int n;
    chk("dbgRst", {31'h0, debugPortEnable}, 32'h1);
    waitExec(n);
    chk("holdoff", {31'h0, (n >= HOLD - 1 && n <= HOLD + 3)}, 32'h1);
    rdChk("cfgRst", `CCID_OFS_CFGCTL, 32'hFFFF_FFFF, 32'h0000_000F);
    rdChk("idRead", `CCID_OFS_PARTID, 32'hFFFF_FFFF, {REV, PID});
    wr(`CCID_OFS_PARTID, 32'h0000_0000);
    rdChk("idWrite", `CCID_OFS_PARTID, 32'hFFFF_FFFF, {REV, PID});
  endtask

  task automatic tCfgBits;
    // All ones without unlock: locks stay clear, reserved bits stay fixed
    wr(`CCID_OFS_CFGCTL, 32'hFFFF_FFFF);
    rdChk("cfgOnes", `CCID_OFS_CFGCTL, 32'hFFFF_FFFF, 32'h0000_000F);
    wr(`CCID_OFS_CFGCTL, 32'h0000_0000);
    rdChk("cfgZero", `CCID_OFS_CFGCTL, 32'hFFFF_FFFF, 32'h0000_0006);
    repeat (2) @(posedge clock);
    chk("dbgOff", {31'h0, debugPortEnable}, 32'h0);
    chk("tdoOff", {31'h0, twoWireTdoUse}, 32'h0);
    wr(`CCID_OFS_CFGCTL, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk("tdoOn", {31'h0, twoWireTdoUse}, 32'h1);
    chk("dbgStill", {31'h0, debugPortEnable}, 32'h0);
    wr(`CCID_OFS_CFGCTL, 32'h0000_0009);
    rdChk("lockRej", `CCID_OFS_INTSTAT, 32'h0000_0004, 32'h0000_0004);
  endtask

  task automatic tLocks;
    int i;
    wr(`CCID_OFS_INTSTAT, 32'h0000_0007);
    wr(`CCID_OFS_INTMASK, 32'h0000_0004);
    wr(`CCID_OFS_PINSEL, 32'hA5A5_0F0F);
    wr(`CCID_OFS_MODDIS, 32'h0000_00FF);
    // Stores update on the access edge; look once they have settled
    @(negedge clock);
    chk("pinOpen", pinSelect, 32'hA5A5_0F0F);
    chk("modOpen", moduleDisable, 32'h0000_00FF);
    chk("irqQuiet", {31'h0, irq}, 32'h0);
    unlockSeq();
    wr(`CCID_OFS_CFGCTL, 32'h0000_3009);
    rdChk("cfgLock", `CCID_OFS_CFGCTL, 32'hFFFF_FFFF, 32'h0000_300F);
    wr(`CCID_OFS_PINSEL, 32'h0000_0000);
    wr(`CCID_OFS_MODDIS, 32'h0000_0000);
    @(negedge clock);
    chk("pinLocked", pinSelect, 32'hA5A5_0F0F);
    chk("modLocked", moduleDisable, 32'h0000_00FF);
    for (i = 0; i < 4 && irq !== 1'b1; i++) @(posedge clock);
    chk("irqRaised", {31'h0, irq}, 32'h1);
    wr(`CCID_OFS_INTSTAT, 32'h0000_0004);
    repeat (2) @(posedge clock);
    chk("irqCleared", {31'h0, irq}, 32'h0);
    // Stray write between keys must break the sequence
    wr(`CCID_OFS_UNLOCK, `CCID_KEY1);
    wr(`CCID_OFS_INTMASK, 32'h0000_0000);
    wr(`CCID_OFS_UNLOCK, `CCID_KEY2);
    wr(`CCID_OFS_CFGCTL, 32'h0000_0009);
    rdChk("badUnlock", `CCID_OFS_CFGCTL, 32'hFFFF_FFFF, 32'h0000_300F);
    unlockSeq();
    wr(`CCID_OFS_CFGCTL, 32'h0000_1009);
    wr(`CCID_OFS_PINSEL, 32'h0000_1234);
    @(negedge clock);
    chk("pinReopen", pinSelect, 32'h0000_1234);
    // Partial strobes are refused even while open
    strbUse <= 4'h3;
    wr(`CCID_OFS_PINSEL, 32'hFFFF_FFFF);
    strbUse <= 4'hF;
    @(negedge clock);
    chk("pinPartial", pinSelect, 32'h0000_1234);
  endtask

  task automatic tPowerAndBus;
    int n;
    logic [31:0] rd;
    logic        err;
    apb(1'b0, 12'h030, 32'h0000_0000, rd, err);
    chk("unmapErr", {31'h0, err}, 32'h1);
    wr(`CCID_OFS_PWRCTL, 32'h0000_0001);
    repeat (3) @(posedge clock);
    chk("sleepHold", {31'h0, execEnable}, 32'h0);
    wakePin <= 1'b1;
    waitExec(n);
    wakePin <= 1'b0;
    chk("wakeHold", {31'h0, (n >= HOLD)}, 32'h1);
    brownOutPin <= 1'b1;
    repeat (6) @(posedge clock);
    chk("borHold", {31'h0, execEnable}, 32'h0);
    brownOutPin <= 1'b0;
    waitExec(n);
    rdChk("borFlag", `CCID_OFS_RSTCTL, 32'h0000_0002, 32'h0000_0002);
    rdChk("borStat", `CCID_OFS_INTSTAT, 32'h0000_0001, 32'h0000_0001);
    wr(`CCID_OFS_RSTCTL, 32'h0000_0002);
    rdChk("borClr", `CCID_OFS_RSTCTL, 32'h0000_0002, 32'h0000_0000);
  endtask

  // Main sequence: reset held six cycles, then each scenario in turn
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    strbUse = 4'hF;
    brownOutPin = 1'b0;
    wakePin = 1'b0;
    nMismatch = 0;
    checksDone = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    tResetAndId();
    tCfgBits();
    tLocks();
    tPowerAndBus();
    conclude();
  end
endmodule
